/* File: dpbm_defs.vh */
// Constants for the dual-port block memory with FIFO controller
`ifndef DPBM_DEFS_VH
`define DPBM_DEFS_VH
// Port address (bit-granular at the 1-bit width) and word geometry
`define DPBM_AW 15
`define DPBM_DW 72
`define DPBM_WORDS 512
`define DPBM_IW 9
// Width codes: 1, 2, 4, 9, 18, 36, 72 bits
`define DPBM_W1 3'h0
`define DPBM_W2 3'h1
`define DPBM_W4 3'h2
`define DPBM_W9 3'h3
`define DPBM_W18 3'h4
`define DPBM_W36 3'h5
`define DPBM_W72 3'h6
// Write-output behaviour codes
`define DPBM_WM_READ_FIRST 2'h0
`define DPBM_WM_WRITE_FIRST 2'h1
`define DPBM_WM_NO_CHANGE 2'h2
// FIFO pointers count 1/64 of a word; capacities for full and half
`define DPBM_PW 16
`define DPBM_CAP_FULL 16'h8000
`define DPBM_CAP_HALF 16'h4000
// Error correction geometry
`define DPBM_ECC_DW 64
`define DPBM_ECC_CW 8
`define DPBM_ECC_POS_MAX 71
`endif

/* File: dpbm_core.v */
// Dual-port 36Kb block memory with aspect ratios, ECC and FIFO controller
//
// Notes on behaviour
// RL1: 36Kb array, two independent ports
// RL2: Splits into two independent 18Kb halves
// RL3: All port inputs captured on clock
// RL4: Address held until next operation, unless unlatched
// RL5: Optional output register adds one cycle
// RL6: Write output: old, new or unchanged
// RL7: Sleep input gates memory activity
// RL8: Read cascade from adjacent instance
// RL9: Full memory: 32Kx1 up to 512x72
// RL10: Ports may use different aspect ratios
// RL11: Half memory: 16Kx1 up to 512x36
// RL12: Wide words only in one-reader-one-writer mode
// RL13: That mode fixes one side at full width
// RL14: Eight check bits, correct single, detect double
// RL15: Encoder and decoder usable for external memory
// RL16: FIFO in full or half, one/two clocks; both sides run on core_clk, two-clock mode only adds the gray synchroniser
// RL17: FIFO moves own pointers, four flags
// RL18: Threshold flags set by user counts
// RL19: FIFO write and read widths differ
// RL20: FIFO cascade path chains instances
// RL21: Full flags write side, empty read side
// RL22: Corrected and detected error flags per read
`timescale 1ns/1ps
`include "dpbm_defs.vh"
module dpbm_core (
   input wire core_clk,
   input wire arst_n,
   input wire cfg_split,
   input wire one_reader_one_writer_mode,
   input wire [2:0] cfg_a_width,
   input wire [2:0] cfg_b_width,
   input wire [1:0] cfg_a_wr_mode,
   input wire [1:0] cfg_b_wr_mode,
   input wire cfg_addr_latch,
   input wire cfg_out_reg,
   input wire cfg_ecc_en,
   input wire cfg_fifo_mode,
   input wire cfg_fifo_two_clk,
   input wire cfg_casc_in_en,
   input wire [15:0] cfg_afull_thr,
   input wire [15:0] cfg_aempty_thr,
   input wire sleep,
   input wire a_en,
   input wire a_we,
   input wire a_half,
   input wire [14:0] a_addr,
   input wire [71:0] a_din,
   output wire [71:0] a_dout,
   output wire a_sbit_err,
   output wire a_dbit_err,
   input wire b_en,
   input wire b_we,
   input wire b_half,
   input wire b_casc_sel,
   input wire [14:0] b_addr,
   input wire [71:0] b_din,
   output wire [71:0] b_dout,
   output wire b_sbit_err,
   output wire b_dbit_err,
   input wire [71:0] casc_rd_in,
   input wire casc_in_valid,
   input wire [71:0] casc_in_data,
   output reg casc_in_ready_ff,
   output reg fifo_out_valid_ff,
   output reg [71:0] fifo_out_data_ff,
   input wire fifo_out_ready,
   output reg fifo_full_ff,
   output reg fifo_empty_ff,
   output reg fifo_afull_ff,
   output reg fifo_aempty_ff,
   output reg cfg_err_ff,
   input wire [63:0] ext_enc_din,
   output reg [7:0] ext_enc_chk_ff,
   input wire [71:0] ext_dec_din,
   output reg [63:0] ext_dec_dout_ff,
   output reg ext_dec_sbit_ff,
   output reg ext_dec_dbit_ff
);

////////////////////////////////////////////////////////////////////////////
// Functions

// Width in bits of a width code
function [6:0] wbits;
   input [2:0] code;
   begin
      case (code)
         `DPBM_W1: wbits = 7'h01;
         `DPBM_W2: wbits = 7'h02;
         `DPBM_W4: wbits = 7'h04;
         `DPBM_W9: wbits = 7'h09;
         `DPBM_W18: wbits = 7'h12;
         `DPBM_W36: wbits = 7'h24;
         default: wbits = 7'h48;
      endcase
   end
endfunction

// Hamming check bits; data fills the non-power-of-two positions
function [7:0] ecc_enc;
   input [63:0] d;
   integer pos;
   integer j;
   integer k;
   begin
      ecc_enc = 8'h00;
      j = 0;
      for (pos = 1; pos <= `DPBM_ECC_POS_MAX; pos = pos + 1) begin
         if ((pos & (pos - 1)) != 0) begin
            for (k = 0; k < 7; k = k + 1) begin
               if (pos[k])
                  ecc_enc[k] = ecc_enc[k] ^ d[j];
            end
            j = j + 1;
         end
      end
      // Overall parity makes double errors distinguishable
      ecc_enc[7] = ^d ^ ^ecc_enc[6:0];
   end
endfunction

// Flip the data bit that sits at the syndrome position
function [63:0] ecc_fix;
   input [63:0] d;
   input [6:0] syn;
   integer pos;
   integer j;
   begin
      ecc_fix = d;
      j = 0;
      for (pos = 1; pos <= `DPBM_ECC_POS_MAX; pos = pos + 1) begin
         if ((pos & (pos - 1)) != 0) begin
            if (pos[6:0] == syn)
               ecc_fix[j] = ~d[j];
            j = j + 1;
         end
      end
   end
endfunction

function [15:0] gray2bin;
   input [15:0] g;
   integer k;
   begin
      gray2bin[15] = g[15];
      for (k = 14; k >= 0; k = k - 1)
         gray2bin[k] = gray2bin[k + 1] ^ g[k];
   end
endfunction

////////////////////////////////////////////////////////////////////////////
// Configuration checks

// RL12: wide words need one-reader-one-writer mode
wire [2:0] max_w = one_reader_one_writer_mode ?
   (cfg_split ? `DPBM_W36 : `DPBM_W72) : (cfg_split ? `DPBM_W18 : `DPBM_W36);
wire [2:0] fix_w = cfg_split ? `DPBM_W36 : `DPBM_W72;
// RL13: one side pinned at the full word width
wire fix_bad = one_reader_one_writer_mode & (cfg_a_width != fix_w) &
   (cfg_b_width != fix_w);
wire cfg_bad = (cfg_a_width > max_w) | (cfg_b_width > max_w) | fix_bad;
// Port A writes only, port B reads only in that mode
wire [1:0] legal_rd = {1'b1, ~one_reader_one_writer_mode};
wire [1:0] legal_wr = {~one_reader_one_writer_mode, 1'b1};

always @(posedge core_clk or negedge arst_n) begin
   if (!arst_n)
      cfg_err_ff <= 1'b0;
   else
      cfg_err_ff <= cfg_bad;
end

////////////////////////////////////////////////////////////////////////////
// FIFO controller

reg [15:0] wptr_ff;
reg [15:0] rptr_ff;
reg [15:0] wgray_ff;
reg [15:0] rgray_ff;
reg [15:0] wg_s1_ff;
reg [15:0] wg_s2_ff;
reg [15:0] rg_s1_ff;
reg [15:0] rg_s2_ff;
reg head_vld_ff;
reg tail_vld_ff;
reg [71:0] tail_ff;
wire fifo_push;
wire [71:0] fifo_push_data;
wire fifo_pend;

// RL16: capacity follows the full or half array
wire [15:0] cap = cfg_split ? `DPBM_CAP_HALF : `DPBM_CAP_FULL;
// RL19: steps in 1/64 word follow each side's width
wire [15:0] wstep = 16'h0001 << cfg_a_width;
wire [15:0] rstep = 16'h0001 << cfg_b_width;
// RL21: in two-clock mode each side sees the other pointer through a gray synchroniser
wire [15:0] rptr_seen = cfg_fifo_two_clk ? gray2bin(rg_s2_ff) : rptr_ff;
wire [15:0] wptr_seen = cfg_fifo_two_clk ? gray2bin(wg_s2_ff) : wptr_ff;
wire fifo_ok = cfg_fifo_mode & ~sleep & ~cfg_bad;
// RL20: cascade input replaces port A as write source
wire wr_valid = cfg_casc_in_en ? (casc_in_valid & casc_in_ready_ff) :
   (a_en & a_we & ~fifo_full_ff);
wire fifo_wr_go = fifo_ok & wr_valid;
wire [71:0] fifo_wr_data = cfg_casc_in_en ? casc_in_data : a_din;
// RL17: pointers advance on every accepted word
wire [15:0] nxt_wptr = fifo_wr_go ? wptr_ff + wstep : wptr_ff;
wire [15:0] nxt_wcnt = nxt_wptr - rptr_seen;
wire nxt_full = (cap - nxt_wcnt) < wstep;
// Read issue keeps the two-entry buffer from overflowing
wire [1:0] buf_use = {1'b0, head_vld_ff} + {1'b0, tail_vld_ff} +
   {1'b0, fifo_pend};
wire fifo_rd_go = fifo_ok & ((wptr_seen - rptr_ff) >= rstep) &
   (buf_use < 2'h2);
wire [15:0] nxt_rptr = fifo_rd_go ? rptr_ff + rstep : rptr_ff;
wire [15:0] nxt_rcnt = wptr_seen - nxt_rptr;
wire [15:0] wr_addr16 = (wptr_ff & (cap - 16'h0001)) >> cfg_a_width;
wire [15:0] rd_addr16 = (rptr_ff & (cap - 16'h0001)) >> cfg_b_width;

// Pointers and flags; one clock, so two-clock mode is an alias domain
always @(posedge core_clk or negedge arst_n) begin
   if (!arst_n) begin
      wptr_ff <= 16'h0000;
      rptr_ff <= 16'h0000;
      wgray_ff <= 16'h0000;
      rgray_ff <= 16'h0000;
      wg_s1_ff <= 16'h0000;
      wg_s2_ff <= 16'h0000;
      rg_s1_ff <= 16'h0000;
      rg_s2_ff <= 16'h0000;
      fifo_full_ff <= 1'b0;
      fifo_afull_ff <= 1'b0;
      fifo_empty_ff <= 1'b1;
      fifo_aempty_ff <= 1'b1;
      casc_in_ready_ff <= 1'b0;
   end else begin
      wptr_ff <= nxt_wptr;
      rptr_ff <= nxt_rptr;
      wgray_ff <= nxt_wptr ^ (nxt_wptr >> 1);
      rgray_ff <= nxt_rptr ^ (nxt_rptr >> 1);
      wg_s1_ff <= wgray_ff;
      wg_s2_ff <= wg_s1_ff;
      rg_s1_ff <= rgray_ff;
      rg_s2_ff <= rg_s1_ff;
      // RL21: full pair from the write side view
      fifo_full_ff <= nxt_full;
      // RL18: thresholds in words of each side
      fifo_afull_ff <= (nxt_wcnt >> cfg_a_width) >= cfg_afull_thr;
      // RL21: empty pair from the read side view
      fifo_empty_ff <= nxt_rcnt < rstep;
      // RL18: almost-empty at or below the user count
      fifo_aempty_ff <= (nxt_rcnt >> cfg_b_width) <= cfg_aempty_thr;
      casc_in_ready_ff <= fifo_ok & cfg_casc_in_en & ~nxt_full;
   end
end

// Two-entry output buffer; a stalled reader loses no word
always @(posedge core_clk or negedge arst_n) begin
   if (!arst_n) begin
      head_vld_ff <= 1'b0;
      tail_vld_ff <= 1'b0;
      fifo_out_data_ff <= 72'h000000000000000000;
      tail_ff <= 72'h000000000000000000;
   end else begin
      if (head_vld_ff & fifo_out_ready) begin
         head_vld_ff <= tail_vld_ff | fifo_push;
         fifo_out_data_ff <= tail_vld_ff ? tail_ff : fifo_push_data;
         tail_vld_ff <= tail_vld_ff & fifo_push;
         tail_ff <= fifo_push_data;
      end else if (fifo_push) begin
         if (!head_vld_ff) begin
            head_vld_ff <= 1'b1;
            fifo_out_data_ff <= fifo_push_data;
         end else begin
            tail_vld_ff <= 1'b1;
            tail_ff <= fifo_push_data;
         end
      end
   end
end

always @* fifo_out_valid_ff = head_vld_ff;

////////////////////////////////////////////////////////////////////////////
// Ports

// RL1: one array shared by both ports
reg [71:0] mem [0:`DPBM_WORDS-1];

// FIFO mode takes over the port requests
wire [1:0] req_en = cfg_fifo_mode ? {fifo_rd_go, fifo_wr_go} : {b_en, a_en};
wire [1:0] req_we = cfg_fifo_mode ? 2'h1 : {b_we, a_we};
wire [1:0] req_half = cfg_fifo_mode ? 2'h0 : {b_half, a_half};
wire [1:0] req_csel = cfg_fifo_mode ? 2'h0 : {b_casc_sel, 1'b0};
wire [29:0] req_addr = cfg_fifo_mode ? {rd_addr16[14:0], wr_addr16[14:0]} :
   {b_addr, a_addr};
wire [143:0] req_din = {b_din, cfg_fifo_mode ? fifo_wr_data : a_din};
wire [5:0] req_wd = {cfg_b_width, cfg_a_width};
wire [3:0] req_wm = {cfg_b_wr_mode, cfg_a_wr_mode};

genvar p;
generate
   for (p = 0; p < 2; p = p + 1) begin : prt
      reg s1_en_ff;
      reg s1_we_ff;
      reg s1_half_ff;
      reg s1_csel_ff;
      reg s1_fifo_ff;
      reg [14:0] s1_addr_ff;
      reg [71:0] s1_din_ff;
      reg [71:0] q0_ff;
      reg [71:0] out_ff;
      reg sb0_ff;
      reg db0_ff;
      reg sb_ff;
      reg db_ff;
      reg [71:0] q_next;
      // RL3: every port input is captured first
      always @(posedge core_clk or negedge arst_n) begin
         if (!arst_n) begin
            s1_en_ff <= 1'b0;
            s1_we_ff <= 1'b0;
            s1_half_ff <= 1'b0;
            s1_csel_ff <= 1'b0;
            s1_fifo_ff <= 1'b0;
            s1_addr_ff <= 15'h0000;
            s1_din_ff <= 72'h000000000000000000;
         end else begin
            // RL7: sleep blocks any new access
            s1_en_ff <= req_en[p] & ~sleep;
            s1_we_ff <= req_we[p];
            s1_half_ff <= req_half[p];
            s1_csel_ff <= req_csel[p];
            s1_fifo_ff <= cfg_fifo_mode & req_en[p] & (p == 1);
            s1_din_ff <= req_din[72*p +: 72];
            // RL4: address held between operations
            if (!cfg_addr_latch | req_en[p])
               s1_addr_ff <= req_addr[15*p +: 15];
         end
      end
      // RL9: word index and slot from the aspect ratio
      wire [2:0] wd = req_wd[3*p +: 3];
      wire [2:0] sh = 3'h6 - wd;
      wire [6:0] wb = wbits(wd);
      wire [14:0] slot_mask = (15'h0001 << sh) - 15'h0001;
      wire [5:0] slot = s1_addr_ff[5:0] & slot_mask[5:0];
      wire [12:0] off_full = slot * wb;
      wire [6:0] off = off_full[6:0];
      wire [14:0] idx_full = s1_addr_ff >> sh;
      // RL2: in split mode the half select picks an 18Kb half
      // RL11: half arrays address 256 words
      wire [8:0] idx = cfg_split ? {s1_half_ff, idx_full[7:0]} :
         idx_full[8:0];
      wire [71:0] mask = (72'h000000000000000001 << wb) -
         72'h000000000000000001;
      wire [71:0] rd_word = mem[idx];
      wire ecc_on = cfg_ecc_en & (wd == `DPBM_W72);
      // RL14: check bits stored beside the 64 data bits
      wire [71:0] wr_val = ecc_on ?
         {ecc_enc(s1_din_ff[63:0]), s1_din_ff[63:0]} : (s1_din_ff & mask);
      wire [71:0] wr_word = (rd_word & ~(mask << off)) | (wr_val << off);
      wire [71:0] rd_raw = (rd_word >> off) & mask;
      wire [7:0] chk = ecc_enc(rd_raw[63:0]);
      wire [6:0] syn = chk[6:0] ^ rd_raw[70:64];
      wire par = ^rd_raw;
      // RL14: single errors corrected on the fly
      wire [63:0] fixed = (par & (syn != 7'h00)) ?
         ecc_fix(rd_raw[63:0], syn) : rd_raw[63:0];
      wire [71:0] rd_val = ecc_on ? {rd_raw[71:64], fixed} : rd_raw;
      wire wr_go = s1_en_ff & s1_we_ff & legal_wr[p] & ~cfg_bad;
      wire rd_go = s1_en_ff & ~s1_we_ff & legal_rd[p] & ~cfg_bad;
      // RL22: flags tied to the read that raised them
      wire sb_next = rd_go & ecc_on & par;
      wire db_next = rd_go & ecc_on & ~par & (syn != 7'h00);
      // Read data or write-through choice, else hold
      always @* begin
         q_next = q0_ff;
         // RL8: cascaded read from the adjacent instance
         if (s1_csel_ff & s1_en_ff)
            q_next = casc_rd_in;
         else if (rd_go)
            q_next = rd_val;
         else if (wr_go) begin
            // RL6: write output follows the configured choice
            case (req_wm[2*p +: 2])
               `DPBM_WM_READ_FIRST: q_next = rd_raw;
               `DPBM_WM_WRITE_FIRST: q_next = wr_val;
               default: q_next = q0_ff;
            endcase
         end
      end
      // RL5: output register trades a cycle for timing
      always @(posedge core_clk or negedge arst_n) begin
         if (!arst_n) begin
            q0_ff <= 72'h000000000000000000;
            out_ff <= 72'h000000000000000000;
            sb0_ff <= 1'b0;
            db0_ff <= 1'b0;
            sb_ff <= 1'b0;
            db_ff <= 1'b0;
         end else begin
            q0_ff <= q_next;
            sb0_ff <= sb_next;
            db0_ff <= db_next;
            out_ff <= cfg_out_reg ? q0_ff : q_next;
            sb_ff <= cfg_out_reg ? sb0_ff : sb_next;
            db_ff <= cfg_out_reg ? db0_ff : db_next;
         end
      end
   end
endgenerate

// RL10: each port writes at its own width; B wins a same-word clash
always @(posedge core_clk) begin
   if (prt[0].wr_go)
      mem[prt[0].idx] <= prt[0].wr_word;
   if (prt[1].wr_go)
      mem[prt[1].idx] <= prt[1].wr_word;
end

assign fifo_pend = prt[1].s1_fifo_ff & prt[1].s1_en_ff;
assign fifo_push = fifo_pend & ~cfg_bad;
assign fifo_push_data = prt[1].rd_val;
assign a_dout = prt[0].out_ff;
assign a_sbit_err = prt[0].sb_ff;
assign a_dbit_err = prt[0].db_ff;
assign b_dout = prt[1].out_ff;
assign b_sbit_err = prt[1].sb_ff;
assign b_dbit_err = prt[1].db_ff;

////////////////////////////////////////////////////////////////////////////
// Stand-alone ECC for external memory

wire [7:0] ext_chk = ecc_enc(ext_dec_din[63:0]);
wire [6:0] ext_syn = ext_chk[6:0] ^ ext_dec_din[70:64];
wire ext_par = ^ext_dec_din;

// RL15: encode and decode one word per cycle
always @(posedge core_clk or negedge arst_n) begin
   if (!arst_n) begin
      ext_enc_chk_ff <= 8'h00;
      ext_dec_dout_ff <= 64'h0000000000000000;
      ext_dec_sbit_ff <= 1'b0;
      ext_dec_dbit_ff <= 1'b0;
   end else begin
      ext_enc_chk_ff <= ecc_enc(ext_enc_din);
      ext_dec_dout_ff <= (ext_par & (ext_syn != 7'h00)) ?
         ecc_fix(ext_dec_din[63:0], ext_syn) : ext_dec_din[63:0];
      ext_dec_sbit_ff <= ext_par;
      ext_dec_dbit_ff <= ~ext_par & (ext_syn != 7'h00);
   end
end

endmodule

/* File: dpbm_core_sva.sv */
// Checker on the block memory ports: flags, holds, ECC and legality
`timescale 1ns/1ps
module dpbm_core_sva (
   input wire core_clk,
   input wire arst_n,
   input wire cfg_split,
   input wire one_reader_one_writer_mode,
   input wire [2:0] cfg_a_width,
   input wire [2:0] cfg_b_width,
   input wire cfg_fifo_mode,
   input wire cfg_fifo_two_clk,
   input wire cfg_casc_in_en,
   input wire sleep,
   input wire a_en,
   input wire a_we,
   input wire [71:0] a_dout,
   input wire [71:0] b_dout,
   input wire fifo_out_valid_ff,
   input wire [71:0] fifo_out_data_ff,
   input wire fifo_out_ready,
   input wire fifo_full_ff,
   input wire fifo_empty_ff,
   input wire fifo_aempty_ff,
   input wire cfg_err_ff,
   input wire [63:0] ext_enc_din,
   input wire [7:0] ext_enc_chk_ff,
   input wire [71:0] ext_dec_din,
   input wire [63:0] ext_dec_dout_ff,
   input wire ext_dec_sbit_ff,
   input wire ext_dec_dbit_ff
);
   wire mode;
   wire [2:0] max_w;
   wire [2:0] fix_w;
   wire cfg_ill;
   ////////////////////////////////////////////////////////////////////
   // Widest legal code and the code the fixed side must carry
   assign mode = one_reader_one_writer_mode;
   assign max_w = cfg_split ? (mode ? 3'h5 : 3'h4) : (mode ? 3'h6 : 3'h5);
   assign fix_w = cfg_split ? 3'h5 : 3'h6;
   // Too wide, or wide mode with neither side at the fixed width
   assign cfg_ill = cfg_a_width > max_w || cfg_b_width > max_w ||
      (mode && cfg_a_width != fix_w && cfg_b_width != fix_w);
   ////////////////////////////////////////////////////////////////////
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);
   // Three sleeping edges, so a piped read has already landed
   sequence slept3;
      sleep ##1 sleep ##1 sleep;
   endsequence
   // A single-clock FIFO write that the controller must take
   sequence fifo_wr;
      cfg_fifo_mode && !cfg_fifo_two_clk && !cfg_casc_in_en && !sleep &&
      a_en && a_we && !fifo_full_ff && !cfg_err_ff;
   endsequence
   ////////////////////////////////////////////////////////////////////
   rst_flags_a: assert property ($rose(arst_n) |-> fifo_empty_ff &&
      fifo_aempty_ff && !fifo_full_ff && !fifo_out_valid_ff)
      else $error("flags wrong after reset");
   cfg_check_a: assert property ($past(arst_n) |->
      cfg_err_ff == $past(cfg_ill)) else $error("width check wrong");
   flag_excl_a: assert property (!(fifo_full_ff && fifo_empty_ff))
      else $error("full and empty together");
   aempty_set_a: assert property (fifo_empty_ff |-> fifo_aempty_ff)
      else $error("empty without almost empty");
   out_hold_a: assert property (fifo_out_valid_ff && !fifo_out_ready
      |=> fifo_out_valid_ff && $stable(fifo_out_data_ff))
      else $error("stalled output word moved");
   // Read-ahead may move the word on, so empty or valid must show it
   wr_empty_a: assert property (fifo_wr |-> ##[1:3]
      !fifo_empty_ff || fifo_out_valid_ff) else $error("write not seen");
   sleep_hold_a: assert property (slept3 |=> $stable(a_dout) &&
      $stable(b_dout)) else $error("output moved while asleep");
   enc_clean_a: assert property (ext_dec_din ==
      {ext_enc_chk_ff, $past(ext_enc_din)} |=> !ext_dec_sbit_ff &&
      !ext_dec_dbit_ff && ext_dec_dout_ff == $past(ext_enc_din, 2))
      else $error("clean codeword not passed through");
endmodule
bind dpbm_core dpbm_core_sva u_sva (.*);

/* File: dpbm_fabric_sink.sv */
// Fabric-side reader of the FIFO output, stalling at random
`timescale 1ns/1ps
module dpbm_fabric_sink (
   input wire core_clk,
   input wire hold,
   input wire fifo_out_valid_ff,
   input wire [71:0] fifo_out_data_ff,
   output logic fifo_out_ready
);
   logic [71:0] got[$];
   ////////////////////////////////////////////////////////////////////
   // Ready moves at the falling edge; a word counts when the coming
   // rising edge sees valid and ready together
   initial fifo_out_ready = 0;
   always @(negedge core_clk) begin
      fifo_out_ready = !hold && ($urandom % 4 != 0);
      if (fifo_out_valid_ff && fifo_out_ready)
         got.push_back(fifo_out_data_ff);
   end
endmodule

/* File: testbench.sv */
// Self-checking bench for the dual-port block memory
`timescale 1ns/1ps
`include "dpbm_defs.vh"
module testbench;
   logic core_clk, arst_n, cfg_split, one_reader_one_writer_mode, hold;
   logic [2:0] cfg_a_width, cfg_b_width;
   logic [1:0] cfg_a_wr_mode, cfg_b_wr_mode;
   logic cfg_addr_latch, cfg_out_reg, cfg_ecc_en, cfg_fifo_mode, sleep;
   logic cfg_fifo_two_clk, cfg_casc_in_en, casc_in_valid, b_casc_sel;
   logic [15:0] cfg_afull_thr, cfg_aempty_thr;
   logic a_en, a_we, a_half, b_en, b_we, b_half, a_sbit_err, a_dbit_err;
   logic [14:0] a_addr, b_addr, ad;
   logic [71:0] a_din, b_din, casc_rd_in, casc_in_data, ext_dec_din;
   logic [71:0] a_dout, b_dout, fifo_out_data_ff, v1, v2, exp_q[$];
   logic casc_in_ready_ff, fifo_out_valid_ff, fifo_out_ready, fifo_full_ff;
   logic fifo_empty_ff, fifo_afull_ff, fifo_aempty_ff, cfg_err_ff;
   logic b_sbit_err, b_dbit_err, ext_dec_sbit_ff, ext_dec_dbit_ff;
   logic [63:0] ext_enc_din, ext_dec_dout_ff;
   logic [7:0] ext_enc_chk_ff;
   logic [5:0] bt;
   int err_count, cmp_count, p1, p2;
   localparam logic [71:0] M36 = 72'hF_FFFF_FFFF;
   localparam logic [71:0] M64 = 72'hFFFF_FFFF_FFFF_FFFF;
   localparam logic [71:0] MALL = {72{1'b1}};
   dpbm_core DUT (.*);
   dpbm_fabric_sink u_sink (.*);
   ////////////////////////////////////////////////////////////////////
   // Clock, 20 ns period
   initial begin
      core_clk = 0;
      forever #10 core_clk = ~core_clk;
   end
   // Hang guard, far beyond the few thousand cycles the run needs
   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      end_of_test();
   end
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("Compares %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // New layout, then two edges so the width check settles
   task automatic cfg(input s, input m, input [2:0] aw, input [2:0] bw);
      @(negedge core_clk);
      {cfg_split, one_reader_one_writer_mode} = {s, m};
      {cfg_a_width, cfg_b_width, cfg_out_reg} = {aw, bw, 1'b0};
      repeat (2) @(negedge core_clk);
   endtask
   // One port A access over one rising edge, then a cycle for its answer
   task automatic acc_a(input [14:0] a, input [71:0] d, input we, input h);
      @(negedge core_clk);
      {a_en, a_we, a_addr, a_din, a_half} = {1'b1, we, a, d, h};
      @(negedge core_clk);
      a_en = 0;
      @(negedge core_clk);
   endtask
   // Port B read; with the output stage the old word must stand a cycle
   task automatic rd_b(input [14:0] a, input h, input [71:0] e, m);
      v1 = b_dout;
      @(negedge core_clk);
      {b_en, b_addr, b_half} = {1'b1, a, h};
      @(negedge core_clk);
      b_en = 0;
      @(negedge core_clk);
      if (cfg_out_reg) begin
         chk(b_dout & m, v1 & m);
         @(negedge core_clk);
      end
      chk(b_dout & m, e);
   endtask
   // Release the reader and compare every word it took, in order
   task automatic drain();
      hold = 0;
      for (int w = 0; w < 6000 && u_sink.got.size() < exp_q.size(); w++)
         @(negedge core_clk);
      repeat (4) @(negedge core_clk);
      chk(u_sink.got.size(), exp_q.size());
      foreach (exp_q[i]) chk(u_sink.got[i] & M36, exp_q[i]);
      chk(fifo_empty_ff, 1);
      chk(fifo_aempty_ff, 1);
      exp_q = {};
      u_sink.got = {};
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h4dcf));
      {arst_n, cfg_split, one_reader_one_writer_mode, cfg_a_wr_mode} = '0;
      {cfg_b_wr_mode, cfg_out_reg, cfg_ecc_en, cfg_fifo_mode} = '0;
      {cfg_fifo_two_clk, cfg_casc_in_en, sleep, a_en, a_we, a_half} = '0;
      {b_en, b_we, b_half, b_casc_sel, a_addr, b_addr, a_din, b_din} = '0;
      {casc_rd_in, casc_in_valid, casc_in_data, ext_dec_din} = '0;
      {ext_enc_din, cfg_a_width, cfg_b_width} = '0;
      {hold, cfg_addr_latch} = 2'b11;
      cfg_afull_thr = 16'h03E8;
      cfg_aempty_thr = 16'h0004;
      repeat (3) @(negedge core_clk);
      arst_n = 1;
      chk(fifo_empty_ff, 1);
      chk(fifo_full_ff, 0);
      cfg(0, 0, `DPBM_W36, `DPBM_W36);
      for (int i = 0; i < 8; i++) begin
         ad = (i == 7) ? 15'h03FF : 15'($urandom % 1024);
         v2 = {$urandom, $urandom} & M36;
         {cfg_addr_latch, cfg_out_reg} = 2'(i);
         acc_a(ad, v2, 1, 0);
         rd_b(ad, 0, v2, MALL);
      end
      // wide writer against a 1-bit reader, cascade read
      cfg(0, 1, `DPBM_W72, `DPBM_W1);
      for (int i = 0; i < 4; i++) begin
         ad = 15'($urandom % 512);
         bt = (i == 3) ? 6'h3F : 6'($urandom);
         v2 = {8'($urandom), $urandom, $urandom};
         acc_a(ad, v2, 1, 0);
         rd_b({ad[8:0], bt}, 0, 72'(v2[bt]), 72'h1);
      end
      cfg(0, 1, `DPBM_W72, `DPBM_W72);
      rd_b(ad, 0, v2, MALL);
      casc_rd_in = {8'($urandom), $urandom, $urandom};
      b_casc_sel = 1;
      rd_b(0, 0, casc_rd_in, MALL);
      b_casc_sel = 0;
      cfg(0, 0, `DPBM_W36, `DPBM_W36);
      for (int m = 0; m < 3; m++) begin
         cfg_a_wr_mode = 2'(m);
         acc_a(7, 72'h1_2345_6789, 1, 0);
         acc_a(7, 0, 0, 0);
         acc_a(7, 72'hA_BCDE_F012 + m, 1, 0);
         chk(a_dout, (m == 1) ? 72'hA_BCDE_F013 : 72'h1_2345_6789);
      end
      sleep = 1;
      acc_a(7, 72'h5, 1, 0);
      sleep = 0;
      acc_a(7, 0, 0, 0);
      chk(a_dout, 72'hA_BCDE_F014);
      cfg(1, 0, `DPBM_W18, `DPBM_W18);
      acc_a(9, 72'h1_1111, 1, 0);
      acc_a(9, 72'h2_2222, 1, 1);
      rd_b(9, 0, 72'h1_1111, MALL);
      rd_b(9, 1, 72'h2_2222, MALL);
      cfg(1, 0, `DPBM_W36, `DPBM_W18);
      chk(cfg_err_ff, 1);
      // external coder: clean, one flip, two flips
      for (int f = 0; f < 3; f++) begin
         ext_enc_din = {$urandom, $urandom};
         @(negedge core_clk);
         p1 = $urandom % 72;
         p2 = (p1 + 1 + $urandom % 71) % 72;
         v1 = {ext_enc_chk_ff, ext_enc_din};
         v1[p1] = v1[p1] ^ (f > 0);
         v1[p2] = v1[p2] ^ (f > 1);
         ext_dec_din = v1;
         @(negedge core_clk);
         if (f < 2)
            chk(ext_dec_dout_ff, ext_enc_din);
         chk(ext_dec_sbit_ff, f == 1);
         chk(ext_dec_dbit_ff, f == 2);
      end
      // stored words: coded write, and a raw word with one flip
      v2 = {ext_enc_chk_ff, ext_enc_din ^ 64'h20};
      cfg(0, 1, `DPBM_W72, `DPBM_W72);
      acc_a(3, v2, 1, 0);
      cfg_ecc_en = 1;
      rd_b(3, 0, ext_enc_din, M64);
      chk({b_sbit_err, b_dbit_err}, 2'b10);
      acc_a(4, v2, 1, 0);
      rd_b(4, 0, v2 & M64, M64);
      chk({b_sbit_err, b_dbit_err}, 2'b00);
      cfg_ecc_en = 0;
      // fill until refused while the reader stalls
      cfg(0, 0, `DPBM_W36, `DPBM_W36);
      cfg_fifo_mode = 1;
      repeat (1100) begin
         @(negedge core_clk);
         {a_en, a_we, a_din} = {2'b11, {$urandom, $urandom} & M36};
         if (!fifo_full_ff)
            exp_q.push_back(a_din);
      end
      @(negedge core_clk);
      a_en = 0;
      chk(fifo_full_ff, 1);
      chk(fifo_afull_ff, 1);
      drain();
      {cfg_fifo_two_clk, cfg_casc_in_en, hold} = 3'b111;
      for (int i = 0; i < 20; i++) begin
         {casc_in_valid, casc_in_data} = {1'b1, {$urandom, $urandom} & M36};
         exp_q.push_back(casc_in_data);
         for (int w = 0; w < 50 && !casc_in_ready_ff; w++)
            @(negedge core_clk);
         @(negedge core_clk);
      end
      casc_in_valid = 0;
      drain();
      end_of_test();
   end
endmodule
